// ### inc/ssb_pkg.sv
// Package: register map, field positions, reset values and rate constants
package ssb_pkg;
   // Register byte offsets on the Wishbone bus
   localparam logic [3:0] ADDR_STATUS  = 4'h0;
   localparam logic [3:0] ADDR_DIVIDER = 4'h4;
   localparam logic [3:0] ADDR_CONTROL = 4'h8;
   localparam logic [3:0] ADDR_FORMAT  = 4'hC;
   // Status register fields
   localparam int ST_TDE  = 7;
   localparam int ST_RDF  = 6;
   localparam int ST_OVR  = 5;
   localparam int ST_FRM  = 4;
   localparam int ST_PAR  = 3;
   localparam int ST_TX_END_FLAG = 2;
   localparam int ST_MPR  = 1;
   localparam int ST_MPT  = 0;
   // Control register fields
   localparam int CT_TXEN = 5;
   localparam int CT_RXEN = 4;
   localparam int CT_TX_END_IRQ_ENABLE = 2;
   localparam int CT_EXTC = 1;
   localparam int CT_CKOE = 0;
   // Format register fields
   localparam int FM_SYNC = 7;
   localparam int FM_PEN  = 5;
   localparam int FM_MP   = 2;
   localparam int FM_CKS  = 0;
   // Reset values
   localparam logic [7:0] STATUS_RST  = 8'h84;
   localparam logic [7:0] DIVIDER_RST = 8'hFF;
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [7:0] FORMAT_RST  = 8'h00;
   // Divider ticks per half bit at n=0: async 32/2, sync 4/2
   localparam logic [5:0] ASYNC_BASE = 6'h10;
   localparam logic [5:0] SYNC_BASE  = 6'h02;
   localparam int         CKS_W      = 2;
endpackage

// ### logic/ssb_status_baud.sv
// Serial status flags, clock pin selection and bit-rate generator
//
// Summary of operation
// - Ext clock select 1 takes clock from pin; 0 uses internal, drives pin in sync.
// - Async internal clock: clock out enable drives bit clock on pin, else pin free.
// - Clock out enable ignored with external clock or synchronous mode.
// - Status resets to 84h on reset and standby entry.
// - Upper five flags cleared by writing 0, ones ignored; tx end, rx bit read-only.
// - A zero write clears a flag only after reading it set.
// - Tx empty set on holding-to-shifter move and when transmit is disabled.
// - Rx full set when error-free character moves into holding register.
// - Overrun set when another character completes while rx full is set.
// - Framing flag set on zero stop bit in asynchronous mode only.
// - Parity flag set on parity mismatch in async parity formats only.
// - Tx end set when transmit disabled or character ends with tx empty set.
// - Tx end cleared by the same read-then-zero-write sequence as tx empty.
// - Tx end interrupt requested while flag set and its enable is one.
// - Received multiprocessor bit captured only in async multiprocessor reception.
// - Tx multiprocessor bit buffered and moves with the holding byte.
// - Divider register resets to FFh on reset and standby.
// - Async rate F/(64*2^(2n-1)*(N+1)), n picks system or prescaled clock.
// - Prescaled rates halve when peripheral clock runs at half system clock.
// - Sync rate F/(8*2^(2n-1)*(N+1)) with same divider and select.
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module ssb_status_baud
(
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   input  wire logic        standby_i,
   input  wire logic        periph_half_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Shift-register events from the frame logic
   input  wire logic        tx_load_i,
   input  wire logic        tx_char_done_i,
   input  wire logic        rx_char_done_i,
   input  wire logic        rx_stop_bad_i,
   input  wire logic        rx_parity_bad_i,
   input  wire logic        rx_mp_bit_i,
   // To the frame logic
   output logic             tx_mp_bit_o,
   output logic             rx_store_o,
   output logic             tx_enable_o,
   output logic             rx_enable_o,
   output logic             sync_mode_o,
   output logic             bit_tick_o,
   output logic             tx_end_irq_o,
   // Serial clock pin
   input  wire logic        sck_i,
   output logic             sck_o,
   output logic             sck_oe_o,
   output logic             ext_clk_o
);
   import ssb_pkg::*;

   logic [7:0] status_ff;
   logic [7:0] divider_ff;
   logic [7:0] control_ff;
   logic [7:0] format_ff;
   logic [7:0] seen_ff;
   logic       mpt_buf_ff;
   logic       ack_ff;
   logic       sck_s1_ff;
   logic       sck_s2_ff;
   logic [7:0] nxt_status;
   logic [7:0] nxt_seen;
   logic       wr_stb;
   logic       rd_stb;
   logic       sync_m;
   logic       mp_fmt;
   logic [7:0] status_rd;

   function automatic logic hit(input logic [3:0] adr, input logic [3:0] off);
      hit = (adr == off);
   endfunction

   assign sync_m      = format_ff[FM_SYNC];
   assign mp_fmt      = format_ff[FM_MP] & ~sync_m;
   assign tx_enable_o = control_ff[CT_TXEN];
   assign rx_enable_o = control_ff[CT_RXEN];
   assign sync_mode_o = sync_m;
   assign wr_stb      = wb_cyc_i & wb_stb_i & ~ack_ff & wb_we_i & wb_sel_i[0];
   assign rd_stb      = wb_cyc_i & wb_stb_i & ~ack_ff & ~wb_we_i;
   assign status_rd   = {status_ff[7:1], mpt_buf_ff};

   // One wait state; ack drops the cycle after it is given
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         ack_ff <= 1'b0;
      else
         ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
   end
   assign wb_ack_o = ack_ff;

   // Read data registered with the access
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         wb_dat_o <= 32'h0000_0000;
      else if (rd_stb)
      begin
         if (hit(wb_adr_i, ADDR_STATUS))
            wb_dat_o <= {24'h00_0000, status_rd};
         else if (hit(wb_adr_i, ADDR_DIVIDER))
            wb_dat_o <= {24'h00_0000, divider_ff};
         else if (hit(wb_adr_i, ADDR_CONTROL))
            wb_dat_o <= {24'h00_0000, control_ff};
         else if (hit(wb_adr_i, ADDR_FORMAT))
            wb_dat_o <= {24'h00_0000, format_ff};
         else
            wb_dat_o <= 32'h0000_0000;
      end
   end

   // Control, format, divider; standby acts as a synchronous reset
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         divider_ff <= DIVIDER_RST;
         control_ff <= CONTROL_RST;
         format_ff  <= FORMAT_RST;
      end
      else if (standby_i)
      begin
         divider_ff <= DIVIDER_RST;
         control_ff <= CONTROL_RST;
         format_ff  <= FORMAT_RST;
      end
      else if (wr_stb)
      begin
         if (hit(wb_adr_i, ADDR_DIVIDER))
            divider_ff <= wb_dat_i[7:0];
         if (hit(wb_adr_i, ADDR_CONTROL))
            control_ff <= wb_dat_i[7:0];
         if (hit(wb_adr_i, ADDR_FORMAT))
            format_ff <= wb_dat_i[7:0];
      end
   end

   // Status next state; hardware set wins over a software clear
   always_comb
   begin
      nxt_status = status_ff;
      nxt_seen   = seen_ff;
      if (rd_stb && hit(wb_adr_i, ADDR_STATUS))
         nxt_seen = seen_ff | status_ff;
      if (wr_stb && hit(wb_adr_i, ADDR_STATUS))
      begin
         for (int i = ST_PAR; i <= ST_TDE; i++)
         begin
            if (!wb_dat_i[i] && seen_ff[i] && status_ff[i])
            begin
               nxt_status[i] = 1'b0;
               nxt_seen[i]   = 1'b0;
            end
         end
         if (!wb_dat_i[ST_TDE] && seen_ff[ST_TDE] && status_ff[ST_TDE])
            nxt_status[ST_TX_END_FLAG] = 1'b0;
      end
      if (tx_load_i || !tx_enable_o)
         nxt_status[ST_TDE] = 1'b1;
      if (!tx_enable_o || (tx_char_done_i && status_ff[ST_TDE]))
         nxt_status[ST_TX_END_FLAG] = 1'b1;
      if (rx_char_done_i && rx_enable_o)
      begin
         if (status_ff[ST_RDF])
            nxt_status[ST_OVR] = 1'b1;
         else if (rx_store_o)
            nxt_status[ST_RDF] = 1'b1;
         if (!sync_m && rx_stop_bad_i)
            nxt_status[ST_FRM] = 1'b1;
         if (!sync_m && !mp_fmt && format_ff[FM_PEN] && rx_parity_bad_i)
            nxt_status[ST_PAR] = 1'b1;
         if (mp_fmt)
            nxt_status[ST_MPR] = rx_mp_bit_i;
      end
      if (wr_stb && hit(wb_adr_i, ADDR_STATUS))
         nxt_status[ST_MPT] = wb_dat_i[ST_MPT];
      nxt_seen = nxt_seen & nxt_status;
   end

   // Error-free character only reaches the holding register
   assign rx_store_o = rx_char_done_i & rx_enable_o & ~status_ff[ST_RDF]
                     & (sync_m | ~rx_stop_bad_i)
                     & (sync_m | mp_fmt | ~format_ff[FM_PEN] | ~rx_parity_bad_i);

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         status_ff <= STATUS_RST;
         seen_ff   <= 8'h00;
      end
      else if (standby_i)
      begin
         status_ff <= STATUS_RST;
         seen_ff   <= 8'h00;
      end
      else
      begin
         status_ff <= nxt_status;
         seen_ff   <= nxt_seen;
      end
   end

   // Tx multiprocessor bit follows the byte into the shifter
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         mpt_buf_ff <= 1'b0;
      else if (standby_i)
         mpt_buf_ff <= 1'b0;
      else if (wr_stb && hit(wb_adr_i, ADDR_STATUS))
         mpt_buf_ff <= wb_dat_i[ST_MPT];
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         tx_mp_bit_o <= 1'b0;
      else if (tx_load_i)
         tx_mp_bit_o <= mpt_buf_ff & mp_fmt;
   end

   assign tx_end_irq_o = control_ff[CT_TX_END_IRQ_ENABLE] & status_ff[ST_TX_END_FLAG];

   // Bit-rate generator: prescaler, divider, then half-bit stage
   logic [6:0]  pre_ff;
   logic        half_ff;
   logic [5:0]  base_ff;
   logic [7:0]  div_ff;
   logic        pre_tick;
   logic        pre_en;
   logic        div_tick;
   logic        base_tick;
   logic        clk_out_ff;
   logic [6:0]  pre_lim;

   // Prescaled codes run from the peripheral clock, half rate when selected
   always_comb
   begin
      case (format_ff[FM_CKS +: CKS_W])
         2'b00:   pre_lim = 7'h00;
         2'b01:   pre_lim = 7'h03;
         2'b10:   pre_lim = 7'h0F;
         default: pre_lim = 7'h3F;
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         half_ff <= 1'b0;
      else
         half_ff <= ~half_ff;
   end

   // Prescaler only advances on peripheral clock cycles, halving prescaled rates
   assign pre_en   = (format_ff[FM_CKS +: CKS_W] == 2'b00) | ~periph_half_i | half_ff;
   assign pre_tick = (pre_ff == pre_lim) & pre_en;

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         pre_ff <= 7'h00;
      else if (pre_en)
         pre_ff <= (pre_ff >= pre_lim) ? 7'h00 : pre_ff + 7'h01;
   end

   assign div_tick = pre_tick & (div_ff == 8'h00);

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         div_ff <= DIVIDER_RST;
      else if (div_tick || div_ff > divider_ff)
         div_ff <= divider_ff;
      else if (pre_tick)
         div_ff <= div_ff - 8'h01;
   end

   // Base stage: 16 or 2 divider ticks per half bit period
   assign base_tick = div_tick & (base_ff == 6'h01);

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         base_ff <= ASYNC_BASE;
      else if (base_tick || base_ff == 6'h00)
         base_ff <= sync_m ? SYNC_BASE : ASYNC_BASE;
      else if (div_tick)
         base_ff <= base_ff - 6'h01;
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         clk_out_ff <= 1'b1;
      else if (!tx_enable_o && !rx_enable_o && !sync_m)
         clk_out_ff <= 1'b1;
      else if (base_tick)
         clk_out_ff <= ~clk_out_ff;
   end

   // External clock pin synchroniser
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sck_s1_ff <= 1'b1;
         sck_s2_ff <= 1'b1;
      end
      else
      begin
         sck_s1_ff <= sck_i;
         sck_s2_ff <= sck_s1_ff;
      end
   end

   // Bit tick: internal rising clock edge only; held low with external clock
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         bit_tick_o <= 1'b0;
      else if (control_ff[CT_EXTC])
         bit_tick_o <= 1'b0;
      else
         bit_tick_o <= base_tick & ~clk_out_ff;
   end

   assign ext_clk_o = control_ff[CT_EXTC] ? sck_s2_ff : clk_out_ff;
   assign sck_o     = clk_out_ff;
   // Clock out enable only matters for async internal clocking
   assign sck_oe_o  = ~control_ff[CT_EXTC]
                    & (sync_m | control_ff[CT_CKOE]);

endmodule // ssb_status_baud

// ### tb/ssb_status_baud_properties.sv
// Checker: port-level properties of the status and bit-rate block
`timescale 1ns/1ps
module ssb_status_baud_chk
(
   // Clock and reset
   input wire logic        ref_clk_i,
   input wire logic        rst_i,
   input wire logic        standby_i,
   // Wishbone
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // Frame events and controls
   input wire logic        tx_load_i,
   input wire logic        rx_char_done_i,
   input wire logic        rx_stop_bad_i,
   input wire logic        rx_store_o,
   input wire logic        tx_mp_bit_o,
   input wire logic        tx_enable_o,
   input wire logic        rx_enable_o,
   input wire logic        sync_mode_o,
   input wire logic        bit_tick_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_store_then_char;
      rx_store_o ##1 rx_char_done_i;
   endsequence
   AST_ACK_ONE_WAIT: assert property (s_req |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_READ_UPPER_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("upper read bits not zero");
   AST_STORE_CAUSE: assert property (
      rx_store_o |-> rx_char_done_i && !(rx_stop_bad_i && !sync_mode_o))
      else $error("store without clean character");
   AST_OVERRUN_BLOCKS: assert property (s_store_then_char |-> !rx_store_o)
      else $error("store while holding register full");
   AST_MPT_HOLD: assert property (
      (!tx_load_i && !standby_i && !(wb_cyc_i && wb_we_i)) |=> $stable(tx_mp_bit_o))
      else $error("tx multiprocessor bit moved without load");
   AST_STANDBY_CTRL: assert property (
      standby_i |=> !tx_enable_o && !rx_enable_o && !sync_mode_o)
      else $error("controls not cleared by standby");
   AST_TICK_SPACING: assert property (bit_tick_o |=> !bit_tick_o [*3])
      else $error("bit ticks closer than four cycles");
endmodule // ssb_status_baud_chk

bind ssb_status_baud ssb_status_baud_chk i_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
   .standby_i(standby_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_load_i(tx_load_i),
   .rx_char_done_i(rx_char_done_i), .rx_stop_bad_i(rx_stop_bad_i), .rx_store_o(rx_store_o),
   .tx_mp_bit_o(tx_mp_bit_o), .tx_enable_o(tx_enable_o), .rx_enable_o(rx_enable_o),
   .sync_mode_o(sync_mode_o), .bit_tick_o(bit_tick_o));

// ### tb/ssb_frame_model.sv
// Far-side model: frame events and an external serial clock
`timescale 1ns/1ps
module ssb_frame_model
(
   // Bench control
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   input  wire logic       go_i,
   input  wire logic [5:0] cmd_i,
   input  wire logic       sck_run_i,
   // Toward the block
   output logic            tx_load_o,
   output logic            tx_char_done_o,
   output logic            rx_char_done_o,
   output logic            rx_stop_bad_o,
   output logic            rx_parity_bad_o,
   output logic            rx_mp_bit_o,
   output logic            sck_o
);
   logic [1:0] div_ff;
   // Qualifiers inverted outside a pulse so stale values never match
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         {rx_char_done_o, tx_char_done_o, tx_load_o} <= 3'h0;
         {rx_mp_bit_o, rx_parity_bad_o, rx_stop_bad_o} <= 3'h0;
      end
      else
      begin
         {rx_char_done_o, tx_char_done_o, tx_load_o} <= go_i ? cmd_i[2:0] : 3'h0;
         {rx_mp_bit_o, rx_parity_bad_o, rx_stop_bad_o} <= go_i ? cmd_i[5:3] :
            ~{rx_mp_bit_o, rx_parity_bad_o, rx_stop_bad_o};
      end
   end
   // Pin pulled high; clock stands still between frames
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i || !sck_run_i)
      begin
         sck_o  <= 1'b1;
         div_ff <= 2'h0;
      end
      else
      begin
         div_ff <= div_ff + 2'h1;
         sck_o  <= (div_ff == 2'h3) ? ~sck_o : sck_o;
      end
   end
endmodule // ssb_frame_model

// ### tb/ssb_status_baud_tb_top.sv
// Testbench: registers, flags, pin and bit rate of the status block
`timescale 1ns/1ps
module ssb_status_baud_tb_top;
   import ssb_pkg::*;
   logic        clk, rst, stby, half, cyc, stb, we, go, run, ack, tl, td, rxd, sb, pb;
   logic        rx_multiproc_bit, mpo, store, txen, rxen, sync, tick, irq, sck, oe, extc;
   logic [3:0]  adr;
   logic [5:0]  cmd;
   logic [31:0] dat, rd;
   int          n_mismatch, samples_checked, cyc_cnt, n, p;
   // Row: op (0 write, 1 read, 2 event), address, data, expected
   logic [23:0] rows [39] = '{24'h083000, 24'h000000, 24'h100084, 24'h000000, 24'h100000,
      24'h200100, 24'h100080, 24'h200200, 24'h100084, 24'h00FF00, 24'h100085, 24'h200401,
      24'h200400, 24'h1000E5, 24'h009D00, 24'h100085, 24'h200C00, 24'h100095, 24'h0C2000,
      24'h201400, 24'h10009D, 24'h008500, 24'h100085, 24'h0C0400, 24'h202401, 24'h1000C7,
      24'h0C8000, 24'h200400, 24'h1000E7, 24'h1400FF, 24'h045A00, 24'h14005A, 24'h120000,
      24'h0C0400, 24'h200102, 24'h008400, 24'h200002, 24'h200100, 24'h100086};
   logic [19:0] pins [5] = '{20'h01001, 20'h00000, 20'h03000, 20'h00801, 20'h03800};
   logic [35:0] rates [9] = '{36'h000000020, 36'h000100080, 36'h000200200, 36'h000300800,
      36'h000110100, 36'h008000004, 36'h008100010, 36'h008010004, 36'h020000060};

   ssb_status_baud i_dut (.ref_clk_i(clk), .rst_i(rst), .standby_i(stby), .periph_half_i(half),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .tx_load_i(tl), .tx_char_done_i(td),
      .rx_char_done_i(rxd), .rx_stop_bad_i(sb), .rx_parity_bad_i(pb), .rx_mp_bit_i(rx_multiproc_bit),
      .tx_mp_bit_o(mpo), .rx_store_o(store), .tx_enable_o(txen), .rx_enable_o(rxen),
      .sync_mode_o(sync), .bit_tick_o(tick), .tx_end_irq_o(irq), .sck_i(sck), .sck_o(),
      .sck_oe_o(oe), .ext_clk_o(extc));
   ssb_frame_model i_peer (.ref_clk_i(clk), .rst_i(rst), .go_i(go), .cmd_i(cmd),
      .sck_run_i(run), .tx_load_o(tl), .tx_char_done_o(td), .rx_char_done_o(rxd),
      .rx_stop_bad_o(sb), .rx_parity_bad_o(pb), .rx_mp_bit_o(rx_multiproc_bit), .sck_o(sck));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Ceiling well above the slowest rate row
   always @(posedge clk)
   begin
      cyc_cnt++;
      if (cyc_cnt == 40000)
      begin
         n_mismatch++;
         report_and_stop();
      end
   end

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask

   // Classic cycle; read data taken at the ack edge only
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
                     input logic [7:0] e);
      int k;
      k = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= {24'h0, d};
      @(posedge clk);
      while (ack !== 1'b1 && k < 100)
      begin
         @(posedge clk);
         k++;
      end
      if (!w) chk("reg", {24'h0, rd[7:0]}, {24'h0, e});
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask

   task automatic ev(input logic [7:0] c, input logic [7:0] e);
      go  <= 1'b1;
      cmd <= c[5:0];
      @(posedge clk);
      go  <= 1'b0;
      #1 chk("rx_store", 32'(store), 32'(e[0]));
      @(posedge clk);
      #1 chk("tx_mp", 32'(mpo), 32'(e[1]));
      @(posedge clk);
   endtask

   task automatic tick_gap(output int g);
      int k;
      k = 0;
      while (tick !== 1'b1 && k < 5000)
      begin
         @(posedge clk);
         k++;
      end
      @(posedge clk);
      g = 1;
      while (tick !== 1'b1 && g < 5000)
      begin
         @(posedge clk);
         g++;
      end
   endtask

   initial
   begin
      {rst, stby, half, cyc, stb, we, go, run} = 8'h80;
      adr = 4'h0;
      cmd = 6'h00;
      dat = 32'h0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 39; i++)
      begin
         if (rows[i][23:20] == 4'h2) ev(rows[i][15:8], rows[i][7:0]);
         else wb(rows[i][23:20] == 4'h0, rows[i][19:16], rows[i][15:8], rows[i][7:0]);
      end
      $display("flag table done");
      wb(1'b1, ADDR_CONTROL, 8'h04, 8'h00);
      repeat (2) @(posedge clk);
      chk("irq", 32'(irq), 32'h1);
      wb(1'b1, ADDR_CONTROL, 8'h00, 8'h00);
      repeat (2) @(posedge clk);
      chk("irq", 32'(irq), 32'h0);
      stby <= 1'b1;
      @(posedge clk);
      stby <= 1'b0;
      @(posedge clk);
      wb(1'b0, ADDR_STATUS, 8'h00, 8'h84);
      wb(1'b0, ADDR_DIVIDER, 8'h00, 8'hFF);
      $display("irq and standby done");
      for (int i = 0; i < 5; i++)
      begin
         wb(1'b1, ADDR_CONTROL, pins[i][19:12], 8'h00);
         wb(1'b1, ADDR_FORMAT, pins[i][11:4], 8'h00);
         chk("sck_oe", 32'(oe), 32'(pins[i][0]));
      end
      run <= 1'b1;
      n = 0;
      repeat (300)
      begin
         @(posedge clk);
         if (tick === 1'b1) n++;
      end
      chk("ticks", 32'(n), 32'h0);
      run <= 1'b0;
      repeat (8) @(posedge clk);
      chk("ext_clk", 32'(extc), 32'h1);
      $display("clock pin done");
      wb(1'b1, ADDR_CONTROL, 8'h30, 8'h00);
      for (int i = 0; i < 9; i++)
      begin
         half <= rates[i][16];
         wb(1'b1, ADDR_DIVIDER, rates[i][35:28], 8'h00);
         wb(1'b1, ADDR_FORMAT, rates[i][27:20], 8'h00);
         tick_gap(p);
         chk("bit_period", 32'(p), 32'(rates[i][15:0]));
      end
      $display("bit rate done");
      report_and_stop();
   end
endmodule // ssb_status_baud_tb_top
